// File: src/decc_pkg.sv
// constants and types shared by the event counter block
package decc_pkg;
    localparam int NCH = 4;
    localparam int CNT_W = 32;
    localparam int STAB_W = 18;
    localparam int CLK_NS = 100;
    localparam int NDEB = 16;
    // debounce intervals in ns, shortest to longest
    localparam int unsigned DEB_NS [NDEB] = '{
        500, 1500, 3500, 7500, 15500, 31500, 63500, 127500,
        255500, 511500, 1023500, 2047500, 4095500, 8191500, 16383500, 25500000};
    localparam int unsigned DEB_MAX_NS = 25500000;
    localparam int unsigned DEB_MAX_CYC = (DEB_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [CNT_W-1:0] TOP16 = 32'h0000FFFF;
    localparam logic [CNT_W-1:0] TOP32 = 32'hFFFFFFFF;
    localparam logic [STAB_W-1:0] STAB_MAX = 18'h3FFFF;
    // register byte offsets within a channel window
    localparam logic [4:0] OFS_CFG = 5'h00;
    localparam logic [4:0] OFS_ALO = 5'h04;
    localparam logic [4:0] OFS_AHI = 5'h08;
    localparam logic [4:0] OFS_SLO = 5'h0C;
    localparam logic [4:0] OFS_SHI = 5'h10;
    // channel window is 32 bytes at 8'h00..8'h7F, status above
    localparam logic [7:0] ADR_STAT = 8'h80;
    localparam int CFG_W = 15;
    localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

    typedef enum logic [1:0] {
        MODE_TOTAL = 2'h0,
        MODE_CLR_RD = 2'h1,
        MODE_SAT = 2'h2
    } decc_mode_t;

    typedef enum logic [1:0] {
        DEB_BYPASS = 2'h0,
        DEB_AFTER = 2'h1,
        DEB_BEFORE = 2'h2
    } decc_deb_t;

    // field layout of the channel config word, msb first, bits 14:0
    typedef struct packed {
        logic [3:0] deb_time;
        decc_deb_t deb_mode;
        logic invert;
        logic [1:0] map_sel;
        logic dec_en;
        logic gate_en;
        logic latch_map;
        logic width32;
        decc_mode_t mode;
    } decc_cfg_t;

    typedef struct packed {
        decc_cfg_t [NCH-1:0] cfg;
        logic [NCH-1:0] raw;
        logic [NCH-1:0][STAB_W-1:0] stab;
        logic [NCH-1:0] deb;
        logic [NCH-1:0] deb_prev;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [NCH-1:0][CNT_W-1:0] alat;
        logic [NCH-1:0][CNT_W-1:0] slat;
        logic ack;
        logic [31:0] dat;
    } decc_state_t;

    function automatic logic [STAB_W-1:0] deb_cycles(input logic [3:0] idx,
                                                    input int unsigned cap);
        int unsigned c;
        c = (DEB_NS[idx] + CLK_NS - 1) / CLK_NS;
        if (c > cap) begin
            c = cap;
        end
        if (c < 1) begin
            c = 1;
        end
        return c[STAB_W-1:0];
    endfunction
endpackage

// File: src/decc_top.sv
// four debounced event counter channels with a wishbone register port
`timescale 1ns/1ns

// Operation
// - four independent 32-bit counters, fast inputs
// - acquisition start zeroes every counter
// - secondary input picks any debounced channel input
// - scan pulse or secondary edge captures count
// - low-word read captures full 32 bits
// - totalize counts up, sampling never clears
// - totalize clears only at acquisition start
// - wrap at 32 bit boundary in either width
// - clear-on-read zeroes after capturing value
// - saturate stops at FFFF or FFFFFFFF
// - width only matters in saturate mode
// - gate high counts, gate low holds
// - gate source must be another channel
// - primary adds one, secondary subtracts one
// - sixteen debounce intervals, 500 ns to 25.5 ms
// - optional input inversion before debounce
// - bypass passes polarity stage straight through
// - settle-then-accept, accept-then-settle, or bypass
// - scan count readable as two 16-bit slots
// - settle-then-accept waits full interval
// - accept-then-settle follows edge after stable interval
module decc_top #(
    parameter int unsigned deb_max_cyc_p = decc_pkg::DEB_MAX_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [decc_pkg::NCH-1:0] cnt_in_i,
    input wire logic sos_i,
    input wire logic acq_start_i,
    output logic [decc_pkg::NCH-1:0] deb_o
);

    decc_pkg::decc_state_t s_q;
    decc_pkg::decc_state_t s_d;

    logic acc;
    logic [1:0] ch;
    logic [4:0] ofs;
    logic in_win;
    logic [decc_pkg::NCH-1:0] pol;
    logic [decc_pkg::NCH-1:0] chg;
    logic [decc_pkg::NCH-1:0] stable_ok;
    logic [decc_pkg::NCH-1:0][decc_pkg::STAB_W-1:0] thr;
    logic [decc_pkg::NCH-1:0] rise;
    logic [decc_pkg::NCH-1:0] prim_ev;
    logic [decc_pkg::NCH-1:0] sec_ev;
    logic [decc_pkg::NCH-1:0] sec_lvl;
    logic [decc_pkg::NCH-1:0] gate_ok;
    logic [decc_pkg::NCH-1:0] inc;
    logic [decc_pkg::NCH-1:0] dec;
    logic [decc_pkg::NCH-1:0] a_cap;
    logic [decc_pkg::NCH-1:0] s_cap;
    logic [decc_pkg::NCH-1:0] clr;
    logic [decc_pkg::NCH-1:0][decc_pkg::CNT_W-1:0] base;
    logic [decc_pkg::NCH-1:0][decc_pkg::CNT_W-1:0] top;
    logic [decc_pkg::CFG_W-1:0] cfg_w;

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign deb_o = s_q.deb;

    always_comb begin
        s_d = s_q;
        acc = wb_cyc_i && wb_stb_i && !s_q.ack;
        ch = wb_adr_i[6:5];
        ofs = wb_adr_i[4:0];
        in_win = !wb_adr_i[7];
        cfg_w = s_q.cfg[ch];
        pol = '0;
        chg = '0;
        stable_ok = '0;
        thr = '0;
        rise = '0;
        prim_ev = '0;
        sec_ev = '0;
        sec_lvl = '0;
        gate_ok = '0;
        inc = '0;
        dec = '0;
        a_cap = '0;
        s_cap = '0;
        clr = '0;
        base = '0;
        top = '0;

        // one-cycle ack per access
        s_d.ack = acc;
        s_d.dat = 32'h00000000;

        // debounce per channel
        for (int i = 0; i < decc_pkg::NCH; i++) begin
            pol[i] = cnt_in_i[i] ^ s_q.cfg[i].invert;
            chg[i] = pol[i] != s_q.raw[i];
            thr[i] = decc_pkg::deb_cycles(s_q.cfg[i].deb_time, deb_max_cyc_p);
            stable_ok[i] = s_q.stab[i] >= thr[i];
            s_d.raw[i] = pol[i];
            if (chg[i]) begin
                s_d.stab[i] = 18'h00001;
            end else if (s_q.stab[i] != decc_pkg::STAB_MAX) begin
                s_d.stab[i] = s_q.stab[i] + 18'h00001;
            end
            case (s_q.cfg[i].deb_mode)
                decc_pkg::DEB_BYPASS: begin
                    s_d.deb[i] = pol[i];
                end
                decc_pkg::DEB_AFTER: begin
                    if (!chg[i] && stable_ok[i]) begin
                        s_d.deb[i] = pol[i];
                    end
                end
                decc_pkg::DEB_BEFORE: begin
                    if (stable_ok[i]) begin
                        s_d.deb[i] = pol[i];
                    end
                end
                default: begin
                    s_d.deb[i] = pol[i];
                end
            endcase
            s_d.deb_prev[i] = s_q.deb[i];
            rise[i] = s_q.deb[i] && !s_q.deb_prev[i];
        end

        // counters
        for (int i = 0; i < decc_pkg::NCH; i++) begin
            prim_ev[i] = rise[i];
            sec_ev[i] = rise[s_q.cfg[i].map_sel];
            sec_lvl[i] = s_q.deb[s_q.cfg[i].map_sel];
            // self-mapped gate is ignored
            gate_ok[i] = !s_q.cfg[i].gate_en || sec_lvl[i]
                || (s_q.cfg[i].map_sel == 2'(i));
            inc[i] = prim_ev[i] && gate_ok[i];
            dec[i] = s_q.cfg[i].dec_en && sec_ev[i];
            a_cap[i] = acc && !wb_we_i && in_win && ch == 2'(i)
                && ofs == decc_pkg::OFS_ALO;
            s_cap[i] = s_q.cfg[i].latch_map ? sec_ev[i] : sos_i;
            if (a_cap[i]) begin
                s_d.alat[i] = s_q.cnt[i];
            end
            if (s_cap[i]) begin
                s_d.slat[i] = s_q.cnt[i];
            end
            clr[i] = acq_start_i
                || ((s_q.cfg[i].mode == decc_pkg::MODE_CLR_RD)
                    && (a_cap[i] || s_cap[i]));
            base[i] = clr[i] ? 32'h00000000 : s_q.cnt[i];
            top[i] = s_q.cfg[i].width32 ? decc_pkg::TOP32 : decc_pkg::TOP16;
            if (inc[i] && !dec[i]) begin
                if (s_q.cfg[i].mode == decc_pkg::MODE_SAT
                        && base[i] >= top[i]) begin
                    s_d.cnt[i] = base[i];
                end else begin
                    s_d.cnt[i] = base[i] + 32'h00000001;
                end
            end else if (dec[i] && !inc[i]) begin
                s_d.cnt[i] = base[i] - 32'h00000001;
            end else begin
                s_d.cnt[i] = base[i];
            end
        end

        // register access
        if (acc) begin
            if (in_win) begin
                case (ofs)
                    decc_pkg::OFS_CFG: begin
                        if (wb_we_i) begin
                            if (wb_sel_i[0]) begin
                                cfg_w[7:0] = wb_dat_i[7:0];
                            end
                            if (wb_sel_i[1]) begin
                                cfg_w[decc_pkg::CFG_W-1:8] = wb_dat_i[decc_pkg::CFG_W-1:8];
                            end
                            s_d.cfg[ch] = decc_pkg::decc_cfg_t'(cfg_w);
                        end else begin
                            s_d.dat = {17'h00000, s_q.cfg[ch]};
                        end
                    end
                    decc_pkg::OFS_ALO: begin
                        if (!wb_we_i) begin
                            s_d.dat = {16'h0000, s_q.cnt[ch][15:0]};
                        end
                    end
                    decc_pkg::OFS_AHI: begin
                        if (!wb_we_i) begin
                            s_d.dat = {16'h0000, s_q.alat[ch][31:16]};
                        end
                    end
                    decc_pkg::OFS_SLO: begin
                        if (!wb_we_i) begin
                            s_d.dat = {16'h0000, s_q.slat[ch][15:0]};
                        end
                    end
                    decc_pkg::OFS_SHI: begin
                        if (!wb_we_i) begin
                            s_d.dat = {16'h0000, s_q.slat[ch][31:16]};
                        end
                    end
                    default: begin
                        s_d.dat = 32'h00000000;
                    end
                endcase
            end else if (wb_adr_i == decc_pkg::ADR_STAT && !wb_we_i) begin
                s_d.dat = {28'h0000000, s_q.deb};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // decc_top

// File: test/decc_src_model.sv
// pulse source model driving the counter inputs
`timescale 1ns/1ns
module decc_src_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] num_i,
    input wire logic [3:0] wid_i,
    output logic [3:0] pin_o,
    output logic busy_o
);
    initial begin
        pin_o = 4'h0;
        busy_o = 1'b0;
    end
    // pulses high for wid cycles, then low for 8
    always begin
        @(posedge clk_i);
        if (go_i) begin
            busy_o <= 1'b1;
            for (int k = 0; k < num_i; k++) begin
                pin_o <= sel_i;
                repeat (wid_i) @(posedge clk_i);
                pin_o <= 4'h0;
                repeat (8) @(posedge clk_i);
            end
            busy_o <= 1'b0;
        end
    end
endmodule // decc_src_model

// File: test/decc_top_asserts.sv
// assertion checker for the event counter top
`timescale 1ns/1ns
module decc_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [decc_pkg::NCH-1:0] cnt_in_i,
    input wire logic [decc_pkg::NCH-1:0] deb_o
);
    logic wr_seen_q;
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_seen_q <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i) begin
            wr_seen_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (req |=> wb_ack_o)
        else $error("request not acked");
    a_ack_reason: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && wb_dat_o == 32'h0 && deb_o == 4'h0)
        else $error("outputs not cleared by reset");
    a_write_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("write returned data");
    a_stat_read: assert property ($past(req && !wb_we_i && wb_adr_i == decc_pkg::ADR_STAT)
        |-> wb_dat_o[3:0] == $past(deb_o))
        else $error("status does not show debounced levels");
    a_unmapped_zero: assert property ($past(req && !wb_we_i && wb_adr_i > decc_pkg::ADR_STAT)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_deb_bypass: assert property (!wr_seen_q && !$past(rst_i) && !$past(rst_i, 2)
        |-> deb_o == $past(cnt_in_i))
        else $error("bypass path not straight through");
endmodule // decc_top_asserts
bind decc_top decc_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cnt_in_i(cnt_in_i), .deb_o(deb_o));

// File: test/tb_top.sv
// directed bench for the event counter block
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack;
    logic [3:0] pins;
    logic [3:0] deb;
    logic sos = 1'b0;
    logic acq = 1'b0;
    logic go = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] num = 8'h00;
    logic [3:0] wid = 4'h2;
    logic busy;
    int n_fail = 0;
    int num_checks = 0;
    always #50 clk_i = ~clk_i;
    decc_top #(.deb_max_cyc_p(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cnt_in_i(pins), .sos_i(sos), .acq_start_i(acq),
        .deb_o(deb));
    decc_src_model u_src (.clk_i(clk_i), .go_i(go), .sel_i(sel), .num_i(num), .wid_i(wid),
        .pin_o(pins), .busy_o(busy));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && t < 50) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 50) begin
            n_fail++;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        xfer(1'b0, a, 32'h0);
        num_checks++;
        if (rd[15:0] !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, rd[15:0], exp);
        end
    endtask
    task automatic pulse(input logic [3:0] s, input logic [7:0] n, input logic [3:0] w);
        int t;
        t = 0;
        sel <= s;
        num <= n;
        wid <= w;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (busy === 1'b1 && t < 2000) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 2000) begin
            n_fail++;
        end
        repeat (4) @(posedge clk_i);
    endtask
    task automatic strobe(input logic start);
        if (start) begin
            acq <= 1'b1;
        end else begin
            sos <= 1'b1;
        end
        @(posedge clk_i);
        acq <= 1'b0;
        sos <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pulse(4'h1, 8'h05, 4'h2);
        rdchk(8'h80, 16'h0000);
        rdchk(8'h04, 16'h0005);
        rdchk(8'h08, 16'h0000);
        rdchk(8'h04, 16'h0005);
        strobe(1'b0);
        rdchk(8'h0C, 16'h0005);
        rdchk(8'h84, 16'h0000);
        strobe(1'b1);
        rdchk(8'h04, 16'h0000);
        xfer(1'b1, 8'h20, 32'h00000001);
        xfer(1'b1, 8'h40, 32'h000000E0);
        xfer(1'b1, 8'h60, 32'h00000010);
        pulse(4'h2, 8'h03, 4'h2);
        rdchk(8'h24, 16'h0003);
        rdchk(8'h24, 16'h0000);
        pulse(4'h4, 8'h04, 4'h2);
        pulse(4'h8, 8'h01, 4'h2);
        rdchk(8'h44, 16'h0003);
        pulse(4'h8, 8'h02, 4'h2);
        rdchk(8'h64, 16'h0000);
        xfer(1'b1, 8'h00, 32'h00000200);
        pulse(4'h1, 8'h03, 4'h2);
        pulse(4'h1, 8'h02, 4'h8);
        rdchk(8'h04, 16'h0002);
        xfer(1'b1, 8'h00, 32'h00000400);
        pulse(4'h1, 8'h02, 4'h2);
        rdchk(8'h04, 16'h0004);
        xfer(1'b1, 8'h20, 32'h00000101);
        pulse(4'h2, 8'h03, 4'h2);
        rdchk(8'h24, 16'h0004);
        xfer(1'b1, 8'h40, 32'h000000E8);
        pulse(4'h8, 8'h01, 4'h2);
        rdchk(8'h4C, 16'h0001);
        rdchk(8'h50, 16'h0000);
        rdchk(8'h44, 16'h0000);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule // tb_top
